// file: carrier_front_consts.svh
`ifndef CARRIER_FRONT_CONSTS_SVH
`define CARRIER_FRONT_CONSTS_SVH
// ----------------------------------------
// Configuration word addresses
// ----------------------------------------
`define CW_MODE_ADDR      5'h00
`define CW_SYNC_ADDR      5'h01
`define CW_CENTER_ADDR    5'h03
`define CW_PHASE_ADDR     5'h04
`define CW_XFER_FREQ_ADDR 5'h05
`define CW_XFER_PHS_ADDR  5'h06
`define CW_RESAMP_ADDR    5'h0b
// ----------------------------------------
// Field positions
// ----------------------------------------
`define MODE_CLR_BIT      0
`define MODE_OFS_ZERO_BIT 1
`define MODE_LEN_LO       4
`define MODE_BYPASS_BIT   6
`define MODE_DEC_LO       7
`define MODE_SG_LO        13
`define MODE_DSYNC_BIT    19
`define SYNC_XFER_BIT     20
`define RESAMP_LEN_LO     3
`define PHASE_W           10
`define SIN_ADDR_W        18
`define SHIFT_MAX         4'hf
`define RESET_WORD        32'h0000_0000
`endif

// file: carrier_front_pkg.sv
package carrier_front_pkg;
  // Rounded mixer output pair
  typedef struct packed {
    logic signed [14:0] i;
    logic signed [14:0] q;
  } mix_t;
  // Shifted pair handed to the decimator or halfbands
  typedef struct packed {
    logic signed [29:0] i;
    logic signed [29:0] q;
  } shifted_t;
  // Serial loader states
  typedef enum logic {LD_IDLE, LD_SHIFT} ld_state_t;
endpackage

// file: serial_offset_loader.sv
`timescale 1ns/1ps
`include "carrier_front_consts.svh"
module serial_offset_loader (
  input  wire logic        clk_in,     // Port clock
  input  wire logic        rstn_in,    // Async reset, low
  input  wire logic        strobe_in,  // Word start strobe
  input  wire logic        data_in,    // Serial data, MSB first
  input  wire logic [1:0]  len_sel_in, // 00=8 .. 11=32 bits
  output logic      [31:0] word_out,   // Holding register
  output logic             load_out    // Pulse on new word
);
  import carrier_front_pkg::*;
  ld_state_t   state, next_state;     // Loader state
  logic [5:0]  cnt, next_cnt;         // Bits left
  logic [31:0] sr, next_sr;           // Shift register
  logic [31:0] next_word;             // Next holding value
  logic        next_load;             // Next load pulse
  logic [31:0] full;                  // Word with last bit
  // ----------------------------------------
  // Shift and count down
  // ----------------------------------------
  always_comb begin
    full       = {sr[30:0], data_in};
    next_state = state;
    next_cnt   = cnt;
    next_sr    = sr;
    next_word  = word_out;
    next_load  = 1'b0;
    case (state)
      LD_IDLE: begin
        if (strobe_in) begin
          next_state = LD_SHIFT;
          next_cnt   = {1'b0, len_sel_in, 3'h0} + 6'h08;
        end
      end
      LD_SHIFT: begin
        next_sr  = full;
        next_cnt = cnt - 6'h01;
        if (cnt == 6'h01) begin
          // Short words land high, low bits zero
          next_word  = full << {(2'h3 - len_sel_in), 3'h0};
          next_load  = 1'b1;
          next_state = LD_IDLE;
          // Back to back start is taken on the last bit
          if (strobe_in) begin
            next_state = LD_SHIFT;
            next_cnt   = {1'b0, len_sel_in, 3'h0} + 6'h08;
          end
        end
      end
      default: next_state = LD_IDLE;
    endcase
  end
  // Register stage
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state    <= LD_IDLE;
      cnt      <= 6'h00;
      sr       <= `RESET_WORD;
      word_out <= `RESET_WORD;
      load_out <= 1'b0;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      sr       <= next_sr;
      word_out <= next_word;
      load_out <= next_load;
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  sequence byte_start_s;
    state == LD_IDLE && strobe_in && len_sel_in == 2'h0;
  endsequence
  sequence byte_done_s;
    ##9 load_out;
  endsequence
  byte_word_len_a: assert property (byte_start_s |-> byte_done_s)
    else $error("8-bit word not loaded after 8 bits");
  low_bits_zero_a: assert property (
    load_out && $past(len_sel_in) == 2'h1 |-> word_out[15:0] == 16'h0000)
    else $error("Short word low bits not cleared");
endmodule // serial_offset_loader

// file: carrier_front.sv
`timescale 1ns/1ps
`include "carrier_front_consts.svh"
// Behaviour
// - accumulator, offset adder, sine table
// - frequency is center plus serial offset
// - mode bit one zeroes serial offset
// - accumulator advances only on sample enable
// - frequency word is signed two's complement
// - ten-bit phase added to accumulator top
// - top eighteen bits address sine table
// - sample times cosine and sine
// - products rounded symmetrically to fifteen bits
// - writes to five, six copy holds
// - sync copies both holds when enabled
// - transfer clears accumulator when enabled
// - serial word length eight to thirty-two
// - count down, shift, move to hold
// - short words fill top, low zeroed
// - resampler port uses identical procedure
// - shifter uses saturated gain sum
// - gain pins delayed with their sample
// - shifted data to decimator or bypass
// - mode word decimation, shift, bypass fields
// - sync reloads decimation counter when enabled
module carrier_front
  import carrier_front_pkg::*;
#(
  parameter int GAIN_DELAY = 2 // Sample pipeline depth
) (
  input  wire logic                  clk_in,        // 10 MHz clock
  input  wire logic                  rstn_in,       // Async reset, low
  input  wire logic [4:0]            cfg_addr_in,   // Config word address
  input  wire logic [31:0]           cfg_data_in,   // Config write data
  input  wire logic                  cfg_wr_in,     // Config write strobe
  input  wire logic signed [13:0]    sample_in,     // Input sample
  input  wire logic                  input_sample_enable_n, // Sample enable, low
  input  wire logic [2:0]            gain_adjust_pins, // Gain adjust code
  input  wire logic                  front_sync_in, // Sync, high
  input  wire logic                  carrier_offset_serial_in, // Serial offset data
  input  wire logic                  carrier_offset_word_strobe, // Word start
  input  wire logic                  resampler_offset_serial_in, // Serial data
  input  wire logic                  resampler_offset_word_strobe, // Word start
  output carrier_front_pkg::shifted_t data_out,     // Shifted pair
  output logic                       cic_valid_out, // Sample to decimator
  output logic                       bypass_valid_out, // Sample to halfbands
  output logic                       decim_dump_out, // Decimation count end
  output logic [31:0]                resampler_offset_out, // Resampler hold
  output logic [31:0]                freq_word_out  // Summed frequency
);
  import carrier_front_pkg::*;
  // ----------------------------------------
  // Configuration storage
  // ----------------------------------------
  logic [31:0] mode_cw, next_mode_cw;   // Config word 0
  logic [31:0] sync_cw, next_sync_cw;   // Config word 1
  logic [31:0] resamp_cw, next_resamp_cw; // Config word 11
  logic [31:0] center_hold, next_center_hold; // Held center freq
  logic [31:0] center_act, next_center_act;   // Active center freq
  logic [9:0]  phase_hold, next_phase_hold;   // Held phase offset
  logic [9:0]  phase_act, next_phase_act;     // Active phase offset
  logic        wr_freq, wr_phs;               // Transfer writes
  logic        sync_xfer;                     // Sync transfer
  logic        xfer_any;                      // Any transfer
  assign wr_freq   = cfg_wr_in && cfg_addr_in == `CW_XFER_FREQ_ADDR;
  assign wr_phs    = cfg_wr_in && cfg_addr_in == `CW_XFER_PHS_ADDR;
  assign sync_xfer = front_sync_in && sync_cw[`SYNC_XFER_BIT];
  assign xfer_any  = wr_freq || wr_phs || sync_xfer;
  // Next config values; active copies only move on transfer
  always_comb begin
    next_mode_cw     = mode_cw;
    next_sync_cw     = sync_cw;
    next_resamp_cw   = resamp_cw;
    next_center_hold = center_hold;
    next_phase_hold  = phase_hold;
    next_center_act  = center_act;
    next_phase_act   = phase_act;
    if (cfg_wr_in) begin
      case (cfg_addr_in)
        `CW_MODE_ADDR:   next_mode_cw     = cfg_data_in;
        `CW_SYNC_ADDR:   next_sync_cw     = cfg_data_in;
        `CW_RESAMP_ADDR: next_resamp_cw   = cfg_data_in;
        `CW_CENTER_ADDR: next_center_hold = cfg_data_in;
        `CW_PHASE_ADDR:  next_phase_hold  = cfg_data_in[`PHASE_W-1:0];
        default: ;       // Other words belong elsewhere
      endcase
    end
    if (wr_freq || sync_xfer) begin
      next_center_act = center_hold;
    end
    if (wr_phs || sync_xfer) begin
      next_phase_act = phase_hold;
    end
  end
  // Config registers
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode_cw     <= `RESET_WORD;
      sync_cw     <= `RESET_WORD;
      resamp_cw   <= `RESET_WORD;
      center_hold <= `RESET_WORD;
      center_act  <= `RESET_WORD;
      phase_hold  <= 10'h000;
      phase_act   <= 10'h000;
    end else begin
      mode_cw     <= next_mode_cw;
      sync_cw     <= next_sync_cw;
      resamp_cw   <= next_resamp_cw;
      center_hold <= next_center_hold;
      center_act  <= next_center_act;
      phase_hold  <= next_phase_hold;
      phase_act   <= next_phase_act;
    end
  end
  // ----------------------------------------
  // Serial offset ports
  // ----------------------------------------
  logic [31:0] carrier_ofs; // Carrier offset hold
  // Single clock here, so both ports share clk_in
  serial_offset_loader u_carrier_ld (
    .clk_in     (clk_in),
    .rstn_in    (rstn_in),
    .strobe_in  (carrier_offset_word_strobe),
    .data_in    (carrier_offset_serial_in),
    .len_sel_in (mode_cw[`MODE_LEN_LO+1:`MODE_LEN_LO]),
    .word_out   (carrier_ofs),
    .load_out   ()
  );
  serial_offset_loader u_resamp_ld (
    .clk_in     (clk_in),
    .rstn_in    (rstn_in),
    .strobe_in  (resampler_offset_word_strobe),
    .data_in    (resampler_offset_serial_in),
    .len_sel_in (resamp_cw[`RESAMP_LEN_LO+1:`RESAMP_LEN_LO]),
    .word_out   (resampler_offset_out),
    .load_out   ()
  );
  // ----------------------------------------
  // Carrier oscillator
  // ----------------------------------------
  logic [31:0] freq_sum;       // Signed frequency word
  logic [31:0] acc, next_acc;  // Phase accumulator
  logic [17:0] phase_adr;      // Table address
  // Sum wraps mod 2^32; sign picks sideband
  assign freq_sum = center_act +
    (mode_cw[`MODE_OFS_ZERO_BIT] ? `RESET_WORD : carrier_ofs);
  // Offset lands on the top ten bits, wrapping full circle
  assign phase_adr = acc[31:14] + {phase_act, 8'h00};
  // Accumulator step
  always_comb begin
    next_acc = acc;
    if (xfer_any && mode_cw[`MODE_CLR_BIT]) begin
      next_acc = `RESET_WORD;
    end else if (!input_sample_enable_n) begin
      next_acc = acc + freq_sum;
    end
  end
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      acc           <= `RESET_WORD;
      freq_word_out <= `RESET_WORD;
    end else begin
      acc           <= next_acc;
      freq_word_out <= freq_sum;
    end
  end
  // Parabolic half-wave sine; cheap stand-in for a full table
  function automatic logic signed [17:0] sine18(input logic [17:0] p);
    logic [16:0] x;
    logic [33:0] y;
    logic [16:0] mag;
    x   = p[16:0];
    y   = {17'h00000, x} * {17'h00000, 17'h1ffff - x};
    mag = (y[33:15] > 19'h0ffff) ? 17'h0ffff : y[31:15];
    return p[17] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  endfunction
  // Symmetric rounding of a product to 15 bits
  function automatic logic signed [14:0] round15(input logic signed [31:0] v);
    logic signed [31:0] r;
    r = v + (v[31] ? 32'sh0000_7fff : 32'sh0000_8000);
    if (r[31:30] == 2'b01) begin
      return 15'sh3fff; // Mixer products never land here; they stay below 2^30
    end
    return r[30:16];
  endfunction
  // ----------------------------------------
  // Mixer
  // ----------------------------------------
  logic signed [13:0] smp_d;          // Registered sample
  logic signed [17:0] sin_d, cos_d;   // Registered sinusoids
  logic               vld_d, vld_m;   // Sample valid per stage
  mix_t               mix, next_mix;  // Rounded products
  logic signed [31:0] prod_i, prod_q; // Full products
  always_comb begin
    prod_i   = 32'(smp_d * cos_d);
    prod_q   = 32'(smp_d * sin_d);
    next_mix = '{i: round15(prod_i), q: round15(prod_q)};
  end
  // Stage 1 grabs sample with table output, stage 2 rounds
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      smp_d <= 14'sh0000;
      sin_d <= 18'sh00000;
      cos_d <= 18'sh00000;
      vld_d <= 1'b0;
      vld_m <= 1'b0;
      mix   <= '0;
    end else begin
      smp_d <= sample_in;
      sin_d <= sine18(phase_adr);
      cos_d <= sine18(phase_adr + 18'h10000);
      vld_d <= !input_sample_enable_n;
      vld_m <= vld_d;
      mix   <= next_mix;
    end
  end
  // ----------------------------------------
  // Gain pipeline and barrel shifter
  // ----------------------------------------
  logic [2:0] gain_pipe [GAIN_DELAY]; // Gain delay line
  logic [4:0] gain_sum;               // Unsaturated sum
  logic [3:0] shift_amt;              // Saturated shift
  shifted_t   next_data;              // Shifted pair
  // Match the sample path so gain meets its own sample
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int k = 0; k < GAIN_DELAY; k++) begin
        gain_pipe[k] <= 3'h0;
      end
    end else begin
      gain_pipe[0] <= gain_adjust_pins;
      for (int k = 1; k < GAIN_DELAY; k++) begin
        gain_pipe[k] <= gain_pipe[k-1];
      end
    end
  end
  // Each step is 6 dB; sum clamps at fifteen
  always_comb begin
    gain_sum  = {1'b0, mode_cw[`MODE_SG_LO+3:`MODE_SG_LO]} +
                {2'h0, gain_pipe[GAIN_DELAY-1]};
    shift_amt = (gain_sum > 5'h0f) ? `SHIFT_MAX : gain_sum[3:0];
    next_data.i = 30'(mix.i) <<< shift_amt;
    next_data.q = 30'(mix.q) <<< shift_amt;
  end
  // ----------------------------------------
  // Path select and decimation counter
  // ----------------------------------------
  logic       bypass;             // Decimator bypassed
  logic [5:0] dcnt, next_dcnt;    // Decimation counter
  logic       next_dump;          // Count end pulse
  assign bypass = mode_cw[`MODE_BYPASS_BIT];
  // Reload on sync when enabled, else count down per sample
  always_comb begin
    next_dcnt = dcnt;
    next_dump = 1'b0;
    if (front_sync_in && mode_cw[`MODE_DSYNC_BIT]) begin
      next_dcnt = mode_cw[`MODE_DEC_LO+5:`MODE_DEC_LO];
    end else if (vld_m && !bypass) begin
      if (dcnt == 6'h00) begin
        next_dcnt = mode_cw[`MODE_DEC_LO+5:`MODE_DEC_LO];
        next_dump = 1'b1;
      end else begin
        next_dcnt = dcnt - 6'h01;
      end
    end
  end
  // Output registers; bypass assumes enable gaps upstream
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      data_out         <= '0;
      cic_valid_out    <= 1'b0;
      bypass_valid_out <= 1'b0;
      dcnt             <= 6'h00;
      decim_dump_out   <= 1'b0;
    end else begin
      data_out         <= next_data;
      cic_valid_out    <= vld_m && !bypass;
      bypass_valid_out <= vld_m && bypass;
      dcnt             <= next_dcnt;
      decim_dump_out   <= next_dump;
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  acc_step_a: assert property (
    !input_sample_enable_n && !xfer_any |=> acc == $past(acc) + $past(freq_sum))
    else $error("Accumulator did not step by frequency");
  acc_hold_a: assert property (
    input_sample_enable_n && !xfer_any |=> $stable(acc))
    else $error("Accumulator moved without enable");
  ofs_zero_a: assert property (
    mode_cw[`MODE_OFS_ZERO_BIT] |-> freq_sum == center_act)
    else $error("Offset term not zeroed");
  freq_copy_a: assert property (
    wr_freq |=> center_act == $past(center_hold))
    else $error("Frequency transfer failed");
  sync_copy_a: assert property (
    sync_xfer |=> phase_act == $past(phase_hold) && center_act == $past(center_hold))
    else $error("Sync transfer failed");
  acc_clear_a: assert property (
    xfer_any && mode_cw[`MODE_CLR_BIT] |=> acc == `RESET_WORD)
    else $error("Accumulator not cleared on transfer");
  shift_sat_a: assert property (
    gain_sum > 5'h0f |-> shift_amt == 4'hf)
    else $error("Shift sum not saturated");
  gain_align_a: assert property (
    1'b1 ##2 1'b1 |-> gain_pipe[GAIN_DELAY-1] == $past(gain_adjust_pins, 2))
    else $error("Gain pipeline misaligned");
  decim_sync_a: assert property (
    front_sync_in && mode_cw[`MODE_DSYNC_BIT] |=> dcnt == $past(mode_cw[12:7]))
    else $error("Decimation counter not reloaded");
  path_excl_a: assert property (
    !(cic_valid_out && bypass_valid_out))
    else $error("Sample sent to both paths");
endmodule // carrier_front

// file: offset_sender.sv
`timescale 1ns/1ps
// ----------------------------------------
// Serial offset word sender (tracking loop side)
// ----------------------------------------
module offset_sender (
  input  wire logic clk_in,     // Port clock
  output logic      strobe_out, // Word start strobe
  output logic      data_out    // Serial data
);
  // Idle lines at time zero
  initial begin
    strobe_out = 1'b0;
    data_out   = 1'b0;
  end
  // One-clock strobe, then bits MSB first; line inverts after the word
  task automatic send(input logic [31:0] word, input int nbits);
    @(posedge clk_in);
    #1;
    strobe_out = 1'b1;
    @(posedge clk_in);
    #1;
    strobe_out = 1'b0;
    for (int k = 0; k < nbits; k++) begin
      data_out = word[31-k];
      @(posedge clk_in);
      #1;
    end
    data_out = ~data_out; // Stale bit must not look valid
  endtask
endmodule // offset_sender

// file: carrier_nco_mixer_cic_front_test.sv
`timescale 1ns/1ps
`include "carrier_front_consts.svh"
// ----------------------------------------
// Tuning datapath bench
// ----------------------------------------
module carrier_nco_mixer_cic_front_test;
  import carrier_front_pkg::*;
  logic               clk_in = 1'b0;                // 10 MHz clock
  logic               rstn_in = 1'b0;               // Reset, low
  logic [4:0]         cfg_addr_in = 5'h00;          // Config address
  logic [31:0]        cfg_data_in = 32'h0;          // Config data
  logic               cfg_wr_in = 1'b0;             // Config strobe
  logic signed [13:0] sample_in = 14'sh0;           // Sample
  logic               input_sample_enable_n = 1'b1; // Sample enable, low
  logic [2:0]         gain_adjust_pins = 3'h0;      // Gain code
  logic               front_sync_in = 1'b0;         // Sync pulse
  logic               car_data, car_stb, res_data, res_stb; // Serial ports
  shifted_t           data_out;                     // Shifted pair
  logic               cic_valid_out, bypass_valid_out, decim_dump_out;
  logic [31:0]        resampler_offset_out, freq_word_out;
  int                 bad_count = 0;                // Mismatches
  int                 tests_run = 0;                // Comparisons
  logic [31:0]        ctr, off;                     // Expected words
  logic               flip = 1'b0;                  // Expect half-circle turn
  logic               dump_exp = 1'b1;              // Expected count end pulse
  // 100 ns period
  always #50 clk_in = ~clk_in;
  carrier_front i_dut (.clk_in(clk_in), .rstn_in(rstn_in), .cfg_addr_in(cfg_addr_in),
    .cfg_data_in(cfg_data_in), .cfg_wr_in(cfg_wr_in), .sample_in(sample_in),
    .input_sample_enable_n(input_sample_enable_n), .gain_adjust_pins(gain_adjust_pins),
    .front_sync_in(front_sync_in), .carrier_offset_serial_in(car_data),
    .carrier_offset_word_strobe(car_stb), .resampler_offset_serial_in(res_data),
    .resampler_offset_word_strobe(res_stb), .data_out(data_out),
    .cic_valid_out(cic_valid_out), .bypass_valid_out(bypass_valid_out),
    .decim_dump_out(decim_dump_out), .resampler_offset_out(resampler_offset_out),
    .freq_word_out(freq_word_out));
  offset_sender i_car (.clk_in(clk_in), .strobe_out(car_stb), .data_out(car_data));
  offset_sender i_res (.clk_in(clk_in), .strobe_out(res_stb), .data_out(res_data));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Verdict and end of run
  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // One write cycle; strobe drops for a cycle between writes
  task automatic cfg_write(input logic [4:0] addr, input logic [31:0] data);
    @(posedge clk_in);
    #1;
    cfg_addr_in = addr;
    cfg_data_in = data;
    cfg_wr_in   = 1'b1;
    @(posedge clk_in);
    #1;
    cfg_wr_in   = 1'b0;
  endtask
  // Mode word: shift gain, bypass, length code, zero offset, clear
  function automatic logic [31:0] mode(input logic [3:0] sg, input logic byp,
                                       input logic [1:0] len, input logic zro,
                                       input logic clr);
    return {15'h0, sg, 6'h0, byp, len, 2'h0, zro, clr};
  endfunction
  task automatic settle();
    repeat (3) @(posedge clk_in);
    #1;
  endtask
  task automatic sync_pulse();
    @(posedge clk_in);
    #1;
    front_sync_in = 1'b1;
    @(posedge clk_in);
    #1;
    front_sync_in = 1'b0;
  endtask
  // One sample at zero phase; gain pins differ on later cycles
  task automatic send_sample(input logic signed [13:0] s, input logic [2:0] g,
                             input logic byp, input int sh, input string what);
    int n;
    logic signed [29:0] e;
    n = 0;
    e = flip ? -s : s; // Half circle turns the sample over
    e = e <<< sh;
    @(posedge clk_in);
    #1;
    sample_in = s;
    input_sample_enable_n = 1'b0;
    gain_adjust_pins = g;
    @(posedge clk_in);
    #1;
    input_sample_enable_n = 1'b1;
    gain_adjust_pins = ~g;
    while (n < 6 && (byp ? bypass_valid_out : cic_valid_out) !== 1'b1) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    if (n == 6) begin
      check(what, 64'h1, 64'h0);
      stop_test();
    end else begin
      check(what, 64'(e), 64'(data_out.i));
      check(what, 64'h0, 64'(data_out.q));
      check(what, 64'h0, 64'(byp ? cic_valid_out : bypass_valid_out));
      check(what, 64'(dump_exp && !byp), 64'(decim_dump_out));
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk_in);
    #1;
    rstn_in = 1'b1;
    check("freq after reset", 64'h0, 64'(freq_word_out));
    check("resampler after reset", 64'h0, 64'(resampler_offset_out));
    check("data after reset", 64'h0, 64'(data_out));
    $display("Test reset done");
    // Shift sum, saturation, gain pin alignment, path select
    cfg_write(`CW_MODE_ADDR, mode(4'h0, 1'b1, 2'h0, 1'b0, 1'b0));
    send_sample(14'sd1000, 3'h0, 1'b1, 0, "bypass data");
    cfg_write(`CW_MODE_ADDR, mode(4'h3, 1'b0, 2'h0, 1'b0, 1'b0));
    send_sample(-14'sd1000, 3'h2, 1'b0, 5, "shift data");
    cfg_write(`CW_MODE_ADDR, mode(4'hf, 1'b0, 2'h0, 1'b0, 1'b0));
    send_sample(14'sd1000, 3'h7, 1'b0, 15, "saturated data");
    $display("Test shifter done");
    // Half-circle phase: held first, active after address six
    cfg_write(`CW_PHASE_ADDR, 32'hffff_fe00);
    send_sample(14'sd1000, 3'h0, 1'b0, 15, "phase held");
    cfg_write(`CW_XFER_PHS_ADDR, 32'h0);
    flip = 1'b1;
    send_sample(-14'sd1000, 3'h0, 1'b0, 15, "phase active");
    flip = 1'b0;
    cfg_write(`CW_PHASE_ADDR, 32'h0);
    cfg_write(`CW_XFER_PHS_ADDR, 32'h0);
    $display("Test phase done");
    // Center frequency and serial offsets of every length
    ctr = 32'hf000_0000;
    cfg_write(`CW_CENTER_ADDR, ctr);
    settle();
    check("freq held", 64'h0, 64'(freq_word_out));
    cfg_write(`CW_XFER_FREQ_ADDR, 32'h0);
    settle();
    check("freq active", 64'(ctr), 64'(freq_word_out));
    for (int sel = 0; sel < 4; sel++) begin
      off = 32'h9876_5432 & ~(32'hffff_ffff >> (8 * (sel + 1)));
      cfg_write(`CW_MODE_ADDR, mode(4'h0, 1'b0, sel[1:0], 1'b0, 1'b0));
      cfg_write(`CW_RESAMP_ADDR, {27'h0, sel[1:0], 3'h0});
      fork
        i_car.send(32'h9876_5432, 8 * (sel + 1));
        i_res.send(32'h9876_5432, 8 * (sel + 1));
      join
      settle();
      check("freq sum", 64'(32'(ctr + off)), 64'(freq_word_out));
      check("resampler word", 64'(off), 64'(resampler_offset_out));
    end
    cfg_write(`CW_MODE_ADDR, mode(4'h0, 1'b0, 2'h3, 1'b1, 1'b0));
    settle();
    check("offset zeroed", 64'(ctr), 64'(freq_word_out));
    $display("Test frequency done");
    // Sync transfer, gated by its enable, and accumulator clear
    cfg_write(`CW_SYNC_ADDR, 32'h0);
    cfg_write(`CW_CENTER_ADDR, 32'h4000_0000);
    sync_pulse();
    settle();
    check("sync disabled", 64'(ctr), 64'(freq_word_out));
    cfg_write(`CW_SYNC_ADDR, 32'h0010_0000);
    sync_pulse();
    settle();
    check("sync copy", 64'h4000_0000, 64'(freq_word_out));
    send_sample(14'sd1000, 3'h0, 1'b0, 0, "quarter step start");
    cfg_write(`CW_MODE_ADDR, mode(4'h0, 1'b0, 2'h3, 1'b1, 1'b1));
    cfg_write(`CW_CENTER_ADDR, 32'h0);
    sync_pulse();
    send_sample(14'sd1000, 3'h0, 1'b0, 0, "cleared phase");
    $display("Test sync done");
    // Decimate by three, counter restarted from the sync pin
    cfg_write(`CW_MODE_ADDR, mode(4'h0, 1'b0, 2'h3, 1'b1, 1'b0) | 32'h0008_0100);
    sync_pulse();
    dump_exp = 1'b0;
    send_sample(14'sd1000, 3'h0, 1'b0, 0, "decim first");
    send_sample(14'sd1000, 3'h0, 1'b0, 0, "decim second");
    dump_exp = 1'b1;
    send_sample(14'sd1000, 3'h0, 1'b0, 0, "decim third");
    $display("Test decimation done");
    stop_test();
  end
  // Hang guard
  initial begin
    #3000000;
    check("run time", 64'h1, 64'h0);
    stop_test();
  end
endmodule // carrier_nco_mixer_cic_front_test
